//--- shcp_pkg.sv
package shcp_pkg;
    // serial framing and timing
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned BAUD = 9600;
    localparam int unsigned OVS = 16;
    localparam int unsigned DIV_CYC = CLK_HZ / (BAUD * OVS);
    localparam int unsigned DIV_W = 10;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_CYC - 1);
    localparam int unsigned DATA_BITS = 8;
    localparam logic [3:0] OVS_MID = 4'h7;
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [2:0] BIT_LAST = 3'(DATA_BITS - 1);

    // rear switch pins: index 0 is the serial line, 1 the port select, 2..6 the address
    localparam int unsigned NPIN = 7;
    localparam int unsigned PIN_RX = 0;
    localparam int unsigned PIN_SEL = 1;
    localparam int unsigned PIN_ADR = 2;
    localparam int unsigned ADR_W = 5;
    localparam logic [NPIN-1:0] PIN_RST = 7'h03;

    // front display error code
    localparam logic signed [15:0] ERR_CODE = -16'sd100;
    localparam logic [15:0] ERR_NONE = 16'h0000;

    // register map
    localparam int unsigned AW = 8;
    localparam logic [AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [AW-1:0] OFS_STATUS = 8'h04;
    localparam logic [AW-1:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [AW-1:0] OFS_IRQ_MASK = 8'h0c;
    localparam logic [AW-1:0] OFS_ERR = 8'h10;
    localparam logic [AW-1:0] OFS_TERM = 8'h14;
    localparam logic [AW-1:0] OFS_LAST_CHAR = 8'h18;

    // control bits
    localparam int unsigned CTRL_EN = 0;
    localparam int unsigned CTRL_CLR_ERR = 1;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam logic [7:0] TERM_RST = 8'h0a;

    // status bits
    localparam int unsigned ST_HOLD = 0;
    localparam int unsigned ST_SERIAL = 1;
    localparam int unsigned ST_ERR = 2;
    localparam int unsigned ST_ADR = 8;

    // interrupt bits
    localparam int unsigned NIRQ = 3;
    localparam int unsigned IRQ_CMD = 0;
    localparam int unsigned IRQ_ERR = 1;
    localparam int unsigned IRQ_DONE = 2;

    typedef enum logic [3:0] {
        SHCP_IDLE = 4'h1,
        SHCP_START = 4'h2,
        SHCP_DATA = 4'h4,
        SHCP_STOP = 4'h8
    } shcp_rx_state_t;
endpackage : shcp_pkg

//--- shcp_rx_if.sv
`timescale 1ns/1ps
`default_nettype none
interface shcp_rx_if;
    logic line;
    logic tick;
    logic [7:0] data;
    logic valid;
    logic ferr;
    modport rx (input line, input tick, output data, output valid, output ferr);
    modport host (output line, output tick, input data, input valid, input ferr);
endinterface : shcp_rx_if
`default_nettype wire

//--- shcp_rx.sv
`timescale 1ns/1ps
`default_nettype none
module shcp_rx
    import shcp_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    shcp_rx_if.rx port
);
    shcp_rx_state_t state;
    logic [3:0] cnt;
    logic [2:0] bitn;
    logic [7:0] sr;

    wire at_mid = port.tick && (cnt == OVS_MID);
    wire at_last = port.tick && (cnt == OVS_LAST);

    // R1 - eight bits, one stop
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state <= SHCP_IDLE;
            cnt <= 4'h0;
            bitn <= 3'h0;
            sr <= 8'h00;
            port.data <= 8'h00;
            port.valid <= 1'b0;
            port.ferr <= 1'b0;
        end else begin
            port.valid <= 1'b0;
            port.ferr <= 1'b0;
            // the start state clears the count at mid-bit, so only the bit end stops it here
            if (port.tick && !at_last) begin
                cnt <= cnt + 4'h1;
            end
            unique case (state)
                SHCP_IDLE: begin
                    cnt <= 4'h0;
                    if (!port.line) begin
                        state <= SHCP_START;
                    end
                end
                SHCP_START: begin
                    // a start bit gone high at mid-bit was a glitch
                    if (at_mid) begin
                        cnt <= 4'h0;
                        bitn <= 3'h0;
                        state <= port.line ? SHCP_IDLE : SHCP_DATA;
                    end
                end
                SHCP_DATA: begin
                    if (at_last) begin
                        cnt <= 4'h0;
                        sr <= {port.line, sr[7:1]};
                        bitn <= bitn + 3'h1;
                        if (bitn == BIT_LAST) begin
                            state <= SHCP_STOP;
                        end
                    end
                end
                SHCP_STOP: begin
                    if (at_last) begin
                        state <= SHCP_IDLE;
                        port.data <= sr;
                        port.valid <= port.line;
                        port.ferr <= !port.line;
                    end
                end
            endcase
        end
    end

    sequence s_stop_sample;
        state == SHCP_STOP && at_last;
    endsequence

    AST_FRAME_END: assert property (@(posedge mclk) disable iff (!reset_n) // R1
        s_stop_sample |=> (port.valid ^ port.ferr) && state == SHCP_IDLE)
        else $error("stop bit sample gave no single outcome");
endmodule : shcp_rx
`default_nettype wire

//--- shcp_top.sv
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Contract
// R1 - The serial link runs at 9600 baud with eight data bits, one stop bit and no parity.
// R2 - Host-to-device flow is paced by a hardware modem-control hold-off, not by characters.
// R3 - After a complete command the hold-off output is raised and kept until processing ends.
// R4 - The host checks the hold-off before each character and never queues a second command.
// R5 - A rear select switch picks the serial port or the parallel bus; only that one is active.
// R6 - The parallel bus address is read in binary from five switch positions, 4 down to 0.
// R7 - A corrupted or lost command shows error code -100 on the front display.
// R8 - The host should add a fixed delay between commands if errors still occur.
// R9 - A line-terminator character marks the end of a command and triggers the hold-off.
module shcp_top
    import shcp_pkg::*;
#(
    // mclk cycles per oversampling tick; the default gives 9600 baud
    parameter int unsigned BAUD_DIV = DIV_CYC
)
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic rx_pin,
    input wire logic sel_serial_pin,
    input wire logic [ADR_W-1:0] adr_pin,
    output logic dtr_hold,
    output logic [7:0] cmd_data,
    output logic cmd_valid,
    output logic cmd_end,
    input wire logic proc_done,
    output logic par_active,
    output logic [ADR_W-1:0] bus_addr,
    output logic err_show,
    output logic [15:0] err_code,
    input wire logic [AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq
);
    function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // pin synchronisers: a change counts once stages two and three agree
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_s1;
    logic [NPIN-1:0] pin_s2;
    logic [NPIN-1:0] pin_s3;
    logic [NPIN-1:0] pin;

    assign pin_raw = {adr_pin, sel_serial_pin, rx_pin};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    pin_s1[gi] <= PIN_RST[gi];
                    pin_s2[gi] <= PIN_RST[gi];
                    pin_s3[gi] <= PIN_RST[gi];
                    pin[gi] <= PIN_RST[gi];
                end else begin
                    pin_s1[gi] <= pin_raw[gi];
                    pin_s2[gi] <= pin_s1[gi];
                    pin_s3[gi] <= pin_s2[gi];
                    if (pin_s2[gi] == pin_s3[gi]) begin
                        pin[gi] <= pin_s3[gi];
                    end
                end
            end
        end
    endgenerate

    wire serial_sel = pin[PIN_SEL];

    // oversampling enable, 16 per bit
    logic [DIV_W-1:0] div_cnt;
    logic tick;
    localparam logic [DIV_W-1:0] DIV_END = DIV_W'(BAUD_DIV - 1);
    wire div_wrap = (div_cnt == DIV_END);

    // R1 - 9600 baud rate enable
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt <= '0;
            tick <= 1'b0;
        end else begin
            div_cnt <= div_wrap ? '0 : div_cnt + DIV_W'(1);
            tick <= div_wrap;
        end
    end

    shcp_rx_if rxp ();
    assign rxp.line = pin[PIN_RX];
    assign rxp.tick = tick;

    shcp_rx u_rx (
        .mclk(mclk),
        .reset_n(reset_n),
        .port(rxp)
    );

    // registers
    logic ctrl_en;
    logic [7:0] term_char;
    logic [7:0] last_char;
    logic [NIRQ-1:0] irq_stat;
    logic [NIRQ-1:0] irq_mask;

    wire wr_ctrl = reg_wr && hit(reg_addr, OFS_CTRL);
    wire wr_stat = reg_wr && hit(reg_addr, OFS_IRQ_STAT);
    wire wr_mask = reg_wr && hit(reg_addr, OFS_IRQ_MASK);
    wire wr_term = reg_wr && hit(reg_addr, OFS_TERM);
    wire clr_err = wr_ctrl && reg_wdata[CTRL_CLR_ERR];

    // R5 - serial side only live when selected
    wire rx_live = serial_sel && ctrl_en;
    wire char_in = rx_live && rxp.valid;
    // R9 - terminator ends the command
    wire is_term = (rxp.data == term_char);
    wire char_ok = char_in && !dtr_hold;
    wire term_acc = char_ok && is_term;
    // R7 - characters during hold-off or bad frames are lost
    wire err_evt = (char_in && dtr_hold) || (rx_live && rxp.ferr);
    wire done_evt = dtr_hold && proc_done;

    wire [NIRQ-1:0] events;
    assign events[IRQ_CMD] = term_acc;
    assign events[IRQ_ERR] = err_evt;
    assign events[IRQ_DONE] = done_evt;
    wire [NIRQ-1:0] w1c = wr_stat ? reg_wdata[NIRQ-1:0] : '0;
    // a new event wins over a clear in the same cycle
    wire [NIRQ-1:0] next_irq_stat = (irq_stat & ~w1c) | events;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_en <= CTRL_EN_RST;
            term_char <= TERM_RST;
            irq_mask <= '0;
            irq_stat <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_en <= reg_wdata[CTRL_EN];
            end
            if (wr_term) begin
                term_char <= reg_wdata[7:0];
            end
            if (wr_mask) begin
                irq_mask <= reg_wdata[NIRQ-1:0];
            end
            irq_stat <= next_irq_stat;
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // R2 - hardware hold-off line
    // R3 - raised on command end, held until done
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dtr_hold <= 1'b0;
        end else if (term_acc) begin
            dtr_hold <= 1'b1;
        end else if (proc_done) begin
            dtr_hold <= 1'b0;
        end
    end

    // command character stream to the processor
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_data <= 8'h00;
            cmd_valid <= 1'b0;
            cmd_end <= 1'b0;
            last_char <= 8'h00;
        end else begin
            cmd_valid <= char_ok;
            cmd_end <= term_acc;
            if (char_ok) begin
                cmd_data <= rxp.data;
                last_char <= rxp.data;
            end
        end
    end

    // R7 - error code on display
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            err_show <= 1'b0;
            err_code <= ERR_NONE;
        end else if (err_evt) begin
            err_show <= 1'b1;
            err_code <= ERR_CODE;
        end else if (clr_err) begin
            err_show <= 1'b0;
            err_code <= ERR_NONE;
        end
    end

    // R5 - parallel bus enable
    // R6 - five address switches
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            par_active <= 1'b0;
            bus_addr <= '0;
        end else begin
            par_active <= !serial_sel;
            bus_addr <= pin[PIN_ADR +: ADR_W];
        end
    end

    // read path, data stands the cycle after the strobe
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit(reg_addr, OFS_CTRL)) begin
            rd_mux[CTRL_EN] = ctrl_en;
        end else if (hit(reg_addr, OFS_STATUS)) begin
            rd_mux[ST_HOLD] = dtr_hold;
            rd_mux[ST_SERIAL] = serial_sel;
            rd_mux[ST_ERR] = err_show;
            rd_mux[ST_ADR +: ADR_W] = bus_addr;
        end else if (hit(reg_addr, OFS_IRQ_STAT)) begin
            rd_mux[NIRQ-1:0] = irq_stat;
        end else if (hit(reg_addr, OFS_IRQ_MASK)) begin
            rd_mux[NIRQ-1:0] = irq_mask;
        end else if (hit(reg_addr, OFS_ERR)) begin
            rd_mux[15:0] = err_code;
        end else if (hit(reg_addr, OFS_TERM)) begin
            rd_mux[7:0] = term_char;
        end else if (hit(reg_addr, OFS_LAST_CHAR)) begin
            rd_mux[7:0] = last_char;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    sequence s_cmd_end;
        term_acc;
    endsequence

    sequence s_busy;
        dtr_hold && !proc_done;
    endsequence

    AST_HOLD_ON_TERM: assert property (@(posedge mclk) disable iff (!reset_n) // R9
        s_cmd_end |=> dtr_hold ##0 cmd_end)
        else $error("terminator did not raise hold-off");

    AST_HOLD_KEEPS: assert property (@(posedge mclk) disable iff (!reset_n) // R3
        s_busy |=> dtr_hold)
        else $error("hold-off dropped before processing ended");

    AST_HOLD_RELEASE: assert property (@(posedge mclk) disable iff (!reset_n) // R3
        dtr_hold && proc_done |=> !dtr_hold ##1 irq_stat[IRQ_DONE] || $past(wr_stat))
        else $error("hold-off not released after processing");

    AST_ERR_CODE: assert property (@(posedge mclk) disable iff (!reset_n) // R7
        char_in && dtr_hold |=> err_show && err_code == ERR_CODE && !cmd_valid)
        else $error("character during hold-off not flagged");

    AST_NO_SERIAL_PAR: assert property (@(posedge mclk) disable iff (!reset_n) // R5
        !serial_sel [*2] |=> !cmd_valid && par_active)
        else $error("serial command taken with parallel port selected");

    AST_ADDR: assert property (@(posedge mclk) disable iff (!reset_n) // R6
        $stable(pin[PIN_ADR +: ADR_W]) |=> bus_addr == $past(pin[PIN_ADR +: ADR_W]))
        else $error("bus address does not follow switches");

    AST_NO_CHAR_HELD: assert property (@(posedge mclk) disable iff (!reset_n) // R2
        dtr_hold |=> !cmd_end)
        else $error("command accepted while held off");

    AST_IRQ_LEVEL: assert property (@(posedge mclk) disable iff (!reset_n) // R7
        err_evt && irq_mask[IRQ_ERR] |=> irq)
        else $error("unmasked error did not raise interrupt");

    AST_RDATA_ZERO: assert property (@(posedge mclk) disable iff (!reset_n)
        !reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside read cycle");
endmodule : shcp_top
`default_nettype wire

//--- shcp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module shcp_host_model
    import shcp_pkg::*;
#(
    parameter int unsigned BIT_CYC = DIV_CYC * OVS
)
(
    input wire logic mclk,
    input wire logic dtr_hold,
    output logic line
);
    logic stalled;
    initial begin
        line = 1'b1;
        stalled = 1'b0;
    end
    task automatic put_bit(input logic b);
        line <= b;
        repeat (BIT_CYC) @(posedge mclk);
    endtask : put_bit
    // obey low means the host breaks the hold-off on purpose
    task automatic send(input logic [7:0] ch, input logic obey, input int wait_max);
        int n;
        n = 0;
        stalled = 1'b0;
        while (obey && dtr_hold !== 1'b0 && n < wait_max) begin
            @(posedge mclk);
            n++;
        end
        if (obey && n == wait_max) begin
            stalled = 1'b1;
        end else begin
            // start, lsb first, one stop, no parity
            put_bit(1'b0);
            for (int i = 0; i < DATA_BITS; i++) put_bit(ch[i]);
            put_bit(1'b1);
        end
    endtask : send
endmodule : shcp_host_model
`default_nettype wire

//--- shcp_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module shcp_top_test
    import shcp_pkg::*;
;
    logic mclk = 1'b0;
    // shortened tick keeps each character near 1300 cycles
    localparam int unsigned SIM_DIV = 8;
    logic reset_n, rx_line, sel_serial_pin, proc_done, reg_wr, reg_rd;
    logic [ADR_W-1:0] adr_pin;
    logic [AW-1:0] reg_addr;
    logic [31:0] reg_wdata;
    logic dtr_hold, cmd_valid, cmd_end, par_active, err_show, irq;
    logic [7:0] cmd_data;
    logic [ADR_W-1:0] bus_addr;
    logic [15:0] err_code;
    logic [31:0] reg_rdata;
    int err_count = 0;
    int check_count = 0;
    int vcount = 0;
    logic [7:0] vdata;
    logic vend;

    always #4 mclk = ~mclk;

    shcp_top #(.BAUD_DIV(SIM_DIV)) uut (
        .mclk(mclk), .reset_n(reset_n), .rx_pin(rx_line), .sel_serial_pin(sel_serial_pin),
        .adr_pin(adr_pin), .dtr_hold(dtr_hold), .cmd_data(cmd_data), .cmd_valid(cmd_valid),
        .cmd_end(cmd_end), .proc_done(proc_done), .par_active(par_active),
        .bus_addr(bus_addr), .err_show(err_show), .err_code(err_code),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq)
    );
    shcp_host_model #(.BIT_CYC(SIM_DIV * OVS)) host (
        .mclk(mclk), .dtr_hold(dtr_hold), .line(rx_line)
    );

    // pulses last one cycle, so they are caught here
    always @(posedge mclk) begin
        if (cmd_valid === 1'b1) begin
            vcount <= vcount + 1;
            vdata <= cmd_data;
            vend <= cmd_end;
        end
    end

    task automatic close_out;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [AW-1:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : settle

    initial begin
        #400_000;
        err_count++;
        close_out();
    end

    initial begin
        reset_n = 1'b0;
        sel_serial_pin = 1'b1;
        adr_pin = 5'h15;
        proc_done = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        settle(8);
        chk(32'(bus_addr), 32'h15);
        chk(32'(par_active), 32'h0);
        rd(OFS_STATUS, 32'h1502);
        rd(OFS_CTRL, 32'h1);
        rd(OFS_IRQ_MASK, 32'h0);
        rd(OFS_TERM, 32'h0a);
        rd(8'h1c, 32'h0);
        wr(OFS_TERM, 32'h3b);
        rd(OFS_TERM, 32'h3b);
        wr(OFS_TERM, 32'h0a);
        @(posedge mclk);
        sel_serial_pin <= 1'b0;
        adr_pin <= 5'h0a;
        settle(8);
        chk(32'(par_active), 32'h1);
        rd(OFS_STATUS, 32'h0a00);
        @(posedge mclk);
        sel_serial_pin <= 1'b1;
        adr_pin <= 5'h15;
        settle(8);
        chk(32'(bus_addr), 32'h15);
        wr(OFS_IRQ_MASK, 32'h2);
        // plain character: delivered, no hold-off
        host.send(8'h41, 1'b1, 10);
        settle(100);
        chk(32'(vcount), 32'h1);
        chk(32'(vdata), 32'h41);
        chk(32'(vend), 32'h0);
        chk(32'(dtr_hold), 32'h0);
        rd(OFS_LAST_CHAR, 32'h41);
        // terminator raises the hold-off; its event is masked
        host.send(8'h0a, 1'b1, 10);
        settle(100);
        chk(32'(vcount), 32'h2);
        chk(32'(vend), 32'h1);
        chk(32'(dtr_hold), 32'h1);
        chk(32'(irq), 32'h0);
        rd(OFS_IRQ_STAT, 32'h1);
        // a well-behaved host stalls while held
        host.send(8'h55, 1'b1, 50);
        chk(32'(host.stalled), 32'h1);
        chk(32'(dtr_hold), 32'h1);
        // a host ignoring the hold-off corrupts the command
        host.send(8'h55, 1'b0, 0);
        settle(100);
        chk(32'(vcount), 32'h2);
        chk(32'(err_show), 32'h1);
        chk(32'(err_code), 32'hff9c);
        chk(32'(irq), 32'h1);
        rd(OFS_ERR, 32'hff9c);
        rd(OFS_IRQ_STAT, 32'h3);
        wr(OFS_IRQ_MASK, 32'h7);
        @(posedge mclk);
        proc_done <= 1'b1;
        @(posedge mclk);
        proc_done <= 1'b0;
        settle(1);
        chk(32'(dtr_hold), 32'h0);
        rd(OFS_IRQ_STAT, 32'h7);
        rd(OFS_STATUS, 32'h1506);
        wr(OFS_IRQ_STAT, 32'h7);
        #1;
        chk(32'(irq), 32'h0);
        wr(OFS_CTRL, 32'h3);
        settle(1);
        chk(32'(err_show), 32'h0);
        rd(OFS_STATUS, 32'h1502);
        // a terminator on the deselected serial port changes nothing
        @(posedge mclk);
        sel_serial_pin <= 1'b0;
        settle(8);
        host.send(8'h0a, 1'b1, 10);
        settle(100);
        chk(32'(vcount), 32'h2);
        chk(32'(dtr_hold), 32'h0);
        chk(32'(err_show), 32'h0);
        chk(32'(par_active), 32'h1);
        close_out();
    end
endmodule : shcp_top_test
`default_nettype wire
